// >>> hw/nva_dev.sv
// Purpose: nonvolatile data array access registers and programming engine
// Assumes: porResetn is power-on reset, resetn is system reset
// Notes: engine survives resetn so a running program completes
//
// Behaviour
// - data-space access maps at I/O plus 0x20
// - bit set touches only named bit; bit clear writes no bit
// - software writes zero to reserved bits
// - address bits 15:12 read zero
// - address selects one byte of 512
// - software loads address before any access
// - data register feeds write, receives read
// - mode selects atomic, erase or write
// - mode writes ignored while strobe set
// - reset clears mode unless programming
// - ready interrupt held while strobe clear
// - arm bit self-clears after four cycles
// - strobe starts only while armed
// - software arms then strobes within four
// - no programming during flash self-write
// - strobe clears when programming time ends
// - program start stalls core two cycles
// - read fetches byte, stalls four cycles
// - busy refuses reads and address changes
// - time counted in oscillator cycles
// - software keeps interrupts off during sequence
// - reset lets running programming finish
`timescale 1ns/1ps
`default_nettype none
module nva_dev #(
    parameter int unsigned ATOMIC_RC = nva_pkg::RC_ATOMIC,
    parameter int unsigned SPLIT_RC = nva_pkg::RC_SPLIT,
    parameter int unsigned ADDR_W = 9
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic porResetn,
    input wire logic rcClk,
    input wire logic selfProgramBusy,
    nva_io_if.dev io
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // data-space form of a register's I/O address
    function automatic logic [7:0] dsOf(input logic [7:0] ioA);
        return 8'(ioA + nva_pkg::DS_OFFSET);
    endfunction

    logic [7:0] effAddr;   // address seen in data space
    logic bitOk;           // bit op legal at this address
    logic [7:0] wmask;     // lanes written
    logic wrCtrl;          // write hits nvm_control
    logic wrData;          // write hits nvm_data
    logic wrAddrL;         // write hits nvm_addr_low
    logic wrAddrH;         // write hits nvm_addr_high

    // address map and bit-op lane
    always_comb begin
        effAddr = io.ioSel ? dsOf(io.ioAddr) : io.ioAddr;
        bitOk = !io.bitOp || (io.ioSel && io.ioAddr <= nva_pkg::BIT_IO_MAX);
        wmask = io.bitOp ? io.ioWdata : 8'h_FF;
        wrCtrl = io.ioWr && bitOk && effAddr == dsOf(nva_pkg::CTRL_IO);
        wrData = io.ioWr && bitOk && effAddr == dsOf(nva_pkg::DATA_IO);
        wrAddrL = io.ioWr && bitOk && effAddr == dsOf(nva_pkg::ADDRL_IO);
        wrAddrH = io.ioWr && bitOk && effAddr == dsOf(nva_pkg::ADDRH_IO);
    end

    // ----------------------------------------------------------------
    // oscillator input and reset sampling
    // ----------------------------------------------------------------
    logic rcS1, rcS2, rcS3;   // rcClk synchroniser and edge history
    logic rstS1, rstS2;       // resetn seen as a level

    // two-stage catch of async levels
    always_ff @(posedge clk_sys or negedge porResetn) begin
        if (!porResetn) begin
            rcS1 <= 1'b0;
            rcS2 <= 1'b0;
            rcS3 <= 1'b0;
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
        end else begin
            rcS1 <= rcClk;
            rcS2 <= rcS1;
            rcS3 <= rcS2;
            rstS1 <= resetn;
            rstS2 <= rstS1;
        end
    end

    // ----------------------------------------------------------------
    // register file state
    // ----------------------------------------------------------------
    logic irqEn, next_irqEn;           // ready_irq_enable
    logic [2:0] armCnt, next_armCnt;   // program_arm window
    logic [2:0] stallCnt, next_stallCnt; // core halt cycles
    logic [11:0] nvAddr, next_nvAddr;  // nvm_address
    logic [7:0] dataReg, next_dataReg; // nvm_data
    logic [7:0] rdata, next_rdata;     // read answer
    logic [1:0] mode, next_mode;       // program_mode_select
    // programming engine
    logic busy, next_busy;             // program_strobe
    logic [1:0] opMode, next_opMode;
    logic [ADDR_W-1:0] opAddr, next_opAddr;
    logic [7:0] opData, next_opData;
    logic [nva_pkg::RC_W-1:0] rcCnt, next_rcCnt;

    logic [7:0] mem [2**ADDR_W];       // nonvolatile array
    logic [7:0] ctrlRd;                // nvm_control read view
    logic strobeW, readW, armW;        // strobe bits written as one
    logic start, done, rcEdge;
    logic [nva_pkg::RC_W-1:0] rcLast;  // final count of this op

    // next values of all state except the array and the synchronisers
    always_comb begin
        next_irqEn = irqEn;
        next_armCnt = armCnt;
        next_stallCnt = stallCnt;
        next_nvAddr = nvAddr;
        next_dataReg = dataReg;
        next_rdata = 8'h00;
        next_mode = mode;
        next_busy = busy;
        next_opMode = opMode;
        next_opAddr = opAddr;
        next_opData = opData;
        next_rcCnt = rcCnt;
        ctrlRd = {2'b00, mode, irqEn, armCnt != 3'h0, busy, 1'b0};
        strobeW = wrCtrl && wmask[nva_pkg::STROBE_B] && io.ioWdata[nva_pkg::STROBE_B];
        readW = wrCtrl && wmask[nva_pkg::READ_B] && io.ioWdata[nva_pkg::READ_B];
        armW = wrCtrl && wmask[nva_pkg::ARM_B] && io.ioWdata[nva_pkg::ARM_B];
        rcEdge = rcS2 && !rcS3;
        rcLast = (opMode == nva_pkg::MODE_ATOMIC) ? nva_pkg::RC_W'(ATOMIC_RC - 1)
                                                   : nva_pkg::RC_W'(SPLIT_RC - 1);
        start = strobeW && armCnt != 3'h0 && !busy && !selfProgramBusy
                && mode != nva_pkg::MODE_RSVD;
        done = busy && rcEdge && rcCnt == rcLast;

        if (armCnt != 3'h0) begin
            next_armCnt = 3'(armCnt - 3'h1);
        end
        if (armW) begin
            next_armCnt = nva_pkg::ARM_CYCLES;
        end
        // stall countdown
        if (stallCnt != 3'h0) begin
            next_stallCnt = 3'(stallCnt - 3'h1);
        end
        // control fields
        if (wrCtrl) begin
            next_irqEn = io.ioWdata[nva_pkg::IRQEN_B] & wmask[nva_pkg::IRQEN_B]
                         | irqEn & !wmask[nva_pkg::IRQEN_B];
            if (!busy) begin
                next_mode = (io.ioWdata[nva_pkg::MODE_HI:nva_pkg::MODE_LO]
                             & wmask[nva_pkg::MODE_HI:nva_pkg::MODE_LO])
                            | (mode & ~wmask[nva_pkg::MODE_HI:nva_pkg::MODE_LO]);
            end
        end
        if (!rstS2 && !busy) begin
            next_mode = nva_pkg::MODE_RST;
        end
        if (wrAddrL && !busy) begin
            next_nvAddr[7:0] = io.ioWdata;
        end
        if (wrAddrH && !busy) begin
            next_nvAddr[11:8] = io.ioWdata[3:0];
        end
        if (wrData) begin
            next_dataReg = io.ioWdata;
        end
        if (readW && !busy) begin
            next_dataReg = mem[nvAddr[ADDR_W-1:0]];
            next_stallCnt = nva_pkg::READ_STALL;
        end
        if (start) begin
            next_busy = 1'b1;
            next_opMode = mode;
            next_opAddr = nvAddr[ADDR_W-1:0];
            next_opData = dataReg;
            next_rcCnt = '0;
            next_armCnt = 3'h0;
            next_stallCnt = nva_pkg::PROG_STALL;
        end else if (busy && rcEdge) begin
            next_rcCnt = nva_pkg::RC_W'(rcCnt + 1'b1);
        end
        if (done) begin
            next_busy = 1'b0;
        end
        if (io.ioRd) begin
            unique case (effAddr)
                dsOf(nva_pkg::CTRL_IO): next_rdata = ctrlRd & ~nva_pkg::CTRL_RSVD;
                dsOf(nva_pkg::DATA_IO): next_rdata = dataReg;
                dsOf(nva_pkg::ADDRL_IO): next_rdata = nvAddr[7:0];
                dsOf(nva_pkg::ADDRH_IO): next_rdata = {4'h0, nvAddr[11:8]} & ~nva_pkg::ADDRH_RSVD;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // system-reset registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqEn <= 1'b0;
            armCnt <= 3'h0;
            stallCnt <= 3'h0;
            nvAddr <= 12'h000;
            dataReg <= 8'h00;
            rdata <= 8'h00;
        end else begin
            irqEn <= next_irqEn;
            armCnt <= next_armCnt;
            stallCnt <= next_stallCnt;
            nvAddr <= next_nvAddr;
            dataReg <= next_dataReg;
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge porResetn) begin
        if (!porResetn) begin
            mode <= nva_pkg::MODE_RST;
            busy <= 1'b0;
            opMode <= nva_pkg::MODE_RST;
            opAddr <= '0;
            opData <= 8'h00;
            rcCnt <= '0;
        end else begin
            mode <= next_mode;
            busy <= next_busy;
            opMode <= next_opMode;
            opAddr <= next_opAddr;
            opData <= next_opData;
            rcCnt <= next_rcCnt;
        end
    end

    // array update when time is up
    always_ff @(posedge clk_sys) begin
        if (done) begin
            unique case (opMode)
                nva_pkg::MODE_ATOMIC: mem[opAddr] <= opData;
                nva_pkg::MODE_ERASE: mem[opAddr] <= 8'h_FF;
                nva_pkg::MODE_WRITE: mem[opAddr] <= mem[opAddr] & opData;
                default: mem[opAddr] <= mem[opAddr];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io.ioRdata = rdata;
    assign io.cpuStall = stallCnt != 3'h0;
    assign io.readyIrq = irqEn && io.globalIrqEn && !busy;

endmodule
`default_nettype wire

// >>> hw/nva_pkg.sv
// Purpose: shared constants of the nonvolatile access block
// Assumes: 8-bit I/O register bus, byte-wide nonvolatile array
// Notes: offsets are I/O addresses; data-space view adds the offset below
package nva_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [7:0] DS_OFFSET = 8'h20;   // I/O to data-space shift
    localparam logic [7:0] BIT_IO_MAX = 8'h1F;  // top of bit-addressable range
    localparam logic [7:0] CTRL_IO = 8'h1F;     // nvm_control
    localparam logic [7:0] DATA_IO = 8'h20;     // nvm_data
    localparam logic [7:0] ADDRL_IO = 8'h21;    // nvm_addr_low
    localparam logic [7:0] ADDRH_IO = 8'h22;    // nvm_addr_high

    // ----------------------------------------------------------------
    // nvm_control fields
    // ----------------------------------------------------------------
    localparam int MODE_HI = 5;   // program_mode_select msb
    localparam int MODE_LO = 4;   // program_mode_select lsb
    localparam int IRQEN_B = 3;   // ready_irq_enable
    localparam int ARM_B = 2;     // program_arm
    localparam int STROBE_B = 1;  // program_strobe
    localparam int READ_B = 0;    // read_strobe
    localparam logic [7:0] CTRL_RSVD = 8'h_C0;  // always-zero bits
    localparam logic [7:0] ADDRH_RSVD = 8'h_F0; // always-zero bits
    localparam logic [1:0] MODE_RST = 2'h0;     // mode after reset

    // program modes
    typedef enum logic [1:0] {
        MODE_ATOMIC = 2'h0,
        MODE_ERASE = 2'h1,
        MODE_WRITE = 2'h2,
        MODE_RSVD = 2'h3
    } nva_mode_t;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam logic [2:0] ARM_CYCLES = 3'h4;    // arm window
    localparam logic [2:0] PROG_STALL = 3'h2;    // cpu halt on program
    localparam logic [2:0] READ_STALL = 3'h4;    // cpu halt on read
    localparam int ATOMIC_US = 3400;             // erase+write time
    localparam int SPLIT_US = 1800;              // erase or write time
    localparam int RC_ATOMIC = 26368;            // oscillator cycles, atomic
    localparam int RC_SPLIT = RC_ATOMIC * SPLIT_US / ATOMIC_US;
    localparam int RC_W = 15;                    // oscillator counter width

endpackage

// >>> hw/nva_io_if.sv
// Purpose: I/O register bus between processor core and access block
// Assumes: both ends on clk_sys
// Notes: carries no clock; the bench joins the two ends
`timescale 1ns/1ps
`default_nettype none
interface nva_io_if;
    logic ioSel;          // address given as I/O address
    logic [7:0] ioAddr;   // I/O or data-space address
    logic ioWr;           // write pulse
    logic ioRd;           // read pulse
    logic bitOp;          // single-bit set or clear
    logic [7:0] ioWdata;  // write data
    logic [7:0] ioRdata;  // read data, one cycle after ioRd
    logic cpuStall;       // core halted
    logic readyIrq;       // ready interrupt request
    logic globalIrqEn;    // status_word interrupt enable

    // ----------------------------------------------------------------
    // views
    // ----------------------------------------------------------------
    modport dev (input ioSel, ioAddr, ioWr, ioRd, bitOp, ioWdata, globalIrqEn,
                 output ioRdata, cpuStall, readyIrq);
    modport cpu (output ioSel, ioAddr, ioWr, ioRd, bitOp, ioWdata, globalIrqEn,
                 input ioRdata, cpuStall, readyIrq);
endinterface
`default_nettype wire

// >>> hw/nva_cpu.sv
// Purpose: processor-side end issuing I/O register accesses
// Assumes: one command in flight; device answers reads next cycle
// Notes: filters unsafe writes before they reach the bus
`timescale 1ns/1ps
`default_nettype none
module nva_cpu (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdWrite,
    input wire logic cmdIoSpace,
    input wire logic cmdBitOp,
    input wire logic [7:0] cmdAddr,
    input wire logic [7:0] cmdData,
    input wire logic [2:0] cmdBit,
    input wire logic irqEnable,
    input wire logic selfProgramBusy,
    output logic respValid,
    output logic [7:0] respData,
    output logic irqPending,
    nva_io_if.cpu io
);

    // ----------------------------------------------------------------
    // command shaping
    // ----------------------------------------------------------------
    logic [7:0] ds;          // data-space address of command
    logic [7:0] wd;          // data after filtering
    logic inMap;             // address is one of ours
    logic isCtrl;
    logic fire;
    logic sel, next_sel;
    logic [7:0] addr, next_addr;
    logic wr, next_wr, rd, next_rd, bop, next_bop;
    logic [7:0] wdat, next_wdat;
    logic rdPend, next_rdPend;
    logic addrLoaded, next_addrLoaded;
    logic [2:0] holdCnt, next_holdCnt;   // interrupt hold-off

    // filter and launch
    always_comb begin
        ds = cmdIoSpace ? 8'(cmdAddr + nva_pkg::DS_OFFSET) : cmdAddr;
        isCtrl = ds == 8'(nva_pkg::CTRL_IO + nva_pkg::DS_OFFSET);
        inMap = isCtrl || ds == 8'(nva_pkg::DATA_IO + nva_pkg::DS_OFFSET)
                || ds == 8'(nva_pkg::ADDRL_IO + nva_pkg::DS_OFFSET)
                || ds == 8'(nva_pkg::ADDRH_IO + nva_pkg::DS_OFFSET);
        // single-bit sets carry the lane as a one-hot mask, clears carry zero
        wd = cmdBitOp ? (cmdData[0] ? 8'(8'h01 << cmdBit) : 8'h00) : cmdData;
        if (isCtrl) begin
            wd = wd & ~nva_pkg::CTRL_RSVD;
        end
        if (ds == 8'(nva_pkg::ADDRH_IO + nva_pkg::DS_OFFSET)) begin
            wd = wd & ~nva_pkg::ADDRH_RSVD;
        end
        // no strobe before address or during flash write
        if (isCtrl && (selfProgramBusy || !addrLoaded)) begin
            wd[nva_pkg::STROBE_B] = 1'b0;
            wd[nva_pkg::READ_B] = 1'b0;
        end
        cmdReady = !io.cpuStall && !wr && !rd;
        fire = cmdValid && cmdReady;
        next_sel = cmdIoSpace;
        next_addr = cmdAddr;
        next_bop = cmdBitOp;
        next_wdat = wd;
        next_wr = fire && cmdWrite && inMap;
        next_rd = fire && !cmdWrite;
        next_rdPend = rd;
        next_addrLoaded = addrLoaded
                          || (next_wr && ds == 8'(nva_pkg::ADDRL_IO + nva_pkg::DS_OFFSET));
        next_holdCnt = (holdCnt != 3'h0) ? 3'(holdCnt - 3'h1) : 3'h0;
        // interrupts held off from the arm write through the first three of the four arm-window cycles
        if (next_wr && isCtrl && wd[nva_pkg::ARM_B]) begin
            next_holdCnt = nva_pkg::ARM_CYCLES;
        end
    end

    // registered bus drive
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel <= 1'b0;
            addr <= 8'h00;
            wr <= 1'b0;
            rd <= 1'b0;
            bop <= 1'b0;
            wdat <= 8'h00;
            rdPend <= 1'b0;
            addrLoaded <= 1'b0;
            holdCnt <= 3'h0;
        end else begin
            sel <= next_sel;
            addr <= next_addr;
            wr <= next_wr;
            rd <= next_rd;
            bop <= next_bop;
            wdat <= next_wdat;
            rdPend <= next_rdPend;
            addrLoaded <= next_addrLoaded;
            holdCnt <= next_holdCnt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io.ioSel = sel;
    assign io.ioAddr = addr;
    assign io.ioWr = wr;
    assign io.ioRd = rd;
    assign io.bitOp = bop;
    assign io.ioWdata = wdat;
    assign io.globalIrqEn = irqEnable && holdCnt == 3'h0;
    assign respValid = rdPend;
    assign respData = io.ioRdata;
    assign irqPending = io.readyIrq;

endmodule
`default_nettype wire

// >>> testbench/nva_assertions.sv
// Purpose: bus-level checks between the core end and the access block
// Assumes: one clk_sys domain, resetn active low
// Notes: watches the nva_io_if signals only
`timescale 1ns/1ps
`default_nettype none
module nva_assertions (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ioSel,
    input wire logic [7:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWdata,
    input wire logic [7:0] ioRdata,
    input wire logic cpuStall,
    input wire logic readyIrq,
    input wire logic globalIrqEn
);
    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    logic atCtrl; // control register addressed
    logic atHigh; // address-high register addressed
    logic ctrlWr, progWr, rdWr, rdHigh, rdCtrl;
    assign atCtrl = ioSel ? ioAddr == nva_pkg::CTRL_IO : ioAddr == nva_pkg::CTRL_IO + nva_pkg::DS_OFFSET;
    assign atHigh = ioSel ? ioAddr == nva_pkg::ADDRH_IO : ioAddr == nva_pkg::ADDRH_IO + nva_pkg::DS_OFFSET;
    assign ctrlWr = ioWr && atCtrl;
    assign progWr = ctrlWr && ioWdata[nva_pkg::STROBE_B];
    assign rdWr = ctrlWr && ioWdata[nva_pkg::READ_B];
    assign rdHigh = ioRd && atHigh;
    assign rdCtrl = ioRd && atCtrl;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_RDATA_IDLE: assert property (!$past(ioRd) |-> ioRdata == 8'h00)
        else $error("read data driven without a read");
    AST_ADDRH_ZERO: assert property ($past(rdHigh) |-> ioRdata[7:4] == 4'h0)
        else $error("address high upper bits not zero");
    AST_CTRL_RSVD: assert property ($past(rdCtrl) |-> ioRdata[7:6] == 2'h0 && !ioRdata[0])
        else $error("control reserved bits not zero");
    AST_READ_STALL: assert property ($rose(cpuStall) && $past(rdWr) |-> cpuStall[*4] ##1 !cpuStall)
        else $error("read stall not four cycles");
    AST_PROG_STALL: assert property ($rose(cpuStall) && $past(progWr) |-> cpuStall[*2] ##1 !cpuStall)
        else $error("program stall not two cycles");
    AST_STALL_CAUSE: assert property ($rose(cpuStall) |-> $past(progWr) || $past(rdWr))
        else $error("stall without a strobe write");
    AST_NO_BUS_STALL: assert property (cpuStall |-> !ioWr && !ioRd)
        else $error("bus access while core halted");
    AST_IRQ_GATE: assert property (readyIrq |-> globalIrqEn)
        else $error("ready request without global enable");
    AST_ARM_MASK: assert property (ctrlWr && ioWdata[nva_pkg::ARM_B] |=> !globalIrqEn[*3])
        else $error("interrupts open during arm window");
    AST_IRQ_PROG: assert property ($rose(cpuStall) && $past(progWr) |-> !readyIrq)
        else $error("ready request while programming");

    // main scenarios reached
    COV_READ: cover property ($rose(cpuStall) && $past(rdWr));
    COV_PROG: cover property ($rose(cpuStall) && $past(progWr));
    COV_IRQ: cover property ($rose(readyIrq));
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for both ends
// Assumes: program counts cut to 8 and 4 rc cycles
// Notes: rcClk runs free, unrelated in phase to clk_sys
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys, resetn, porResetn, rcClk, selfProgramBusy;
    logic cmdValid, cmdReady, cmdWrite, cmdIoSpace, cmdBitOp, irqEnable, respValid, irqPending;
    logic [7:0] cmdAddr, cmdData, respData, r;
    logic [2:0] cmdBit;
    int fails, tests_run;
    localparam logic [1:0] MD[3] = '{2'h1, 2'h2, 2'h3}; // erase, write, reserved
    localparam logic [7:0] DV[3] = '{8'h00, 8'h0F, 8'h55}; // data per mode
    localparam logic [7:0] EX[3] = '{8'hFF, 8'h0F, 8'h0F}; // byte afterwards
    nva_io_if bus();
    nva_dev #(.ATOMIC_RC(8), .SPLIT_RC(4)) u_nva_dev (.clk_sys(clk_sys), .resetn(resetn),
        .porResetn(porResetn), .rcClk(rcClk), .selfProgramBusy(selfProgramBusy), .io(bus.dev));
    nva_cpu u_nva_cpu (.clk_sys(clk_sys), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdWrite(cmdWrite), .cmdIoSpace(cmdIoSpace), .cmdBitOp(cmdBitOp), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdBit(cmdBit), .irqEnable(irqEnable), .selfProgramBusy(selfProgramBusy),
        .respValid(respValid), .respData(respData), .irqPending(irqPending), .io(bus.cpu));
    nva_assertions u_nva_assertions (.clk_sys(clk_sys), .resetn(resetn), .ioSel(bus.ioSel),
        .ioAddr(bus.ioAddr), .ioWr(bus.ioWr), .ioRd(bus.ioRd), .ioWdata(bus.ioWdata),
        .ioRdata(bus.ioRdata), .cpuStall(bus.cpuStall), .readyIrq(bus.readyIrq),
        .globalIrqEn(bus.globalIrqEn));

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    // one command, held until taken
    task automatic cmd(input logic w, o, b, input logic [7:0] a, d, input logic [2:0] n);
        int k;
        @(negedge clk_sys);
        {cmdValid, cmdWrite, cmdIoSpace, cmdBitOp, cmdAddr, cmdData, cmdBit} = {1'b1, w, o, b, a, d, n};
        k = 0;
        while (cmdReady !== 1'b1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 200) fails++;
        @(negedge clk_sys);
        cmdValid = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d, input logic o = 1'b1);
        cmd(1'b1, o, 1'b0, a, d, 3'h0);
    endtask
    // read, waits for response
    task automatic rd(input logic [7:0] a, output logic [7:0] v, input logic o = 1'b1);
        int k;
        cmd(1'b0, o, 1'b0, a, 8'h00, 3'h0);
        k = 0;
        while (respValid !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 20) fails++;
        v = respData;
    endtask
    // single-bit set on the control register
    task automatic bs(input int n);
        cmd(1'b1, 1'b1, 1'b1, nva_pkg::CTRL_IO, 8'h01, 3'(n));
    endtask
    task automatic setAddr(input logic [8:0] a);
        wr(nva_pkg::ADDRH_IO, {7'h00, a[8]});
        wr(nva_pkg::ADDRL_IO, a[7:0]);
    endtask
    // program sequence: address, data, mode, arm, strobe
    task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
        setAddr(a);
        wr(nva_pkg::DATA_IO, d);
        wr(nva_pkg::CTRL_IO, {2'h0, m, 4'h8});
        bs(nva_pkg::ARM_B);
        bs(nva_pkg::STROBE_B);
    endtask
    task automatic waitDone();
        int k;
        k = 0;
        do begin
            rd(nva_pkg::CTRL_IO, r);
            k++;
        end while (r[nva_pkg::STROBE_B] !== 1'b0 && k < 100);
        if (k == 100) fails++;
    endtask
    task automatic rdByte(input logic [8:0] a, output logic [7:0] v);
        setAddr(a);
        bs(nva_pkg::READ_B);
        rd(nva_pkg::DATA_IO, v);
    endtask
    task automatic doReset();
        @(negedge clk_sys);
        resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_map();
        wr(8'h41, 8'h5A, 1'b0);
        rd(nva_pkg::ADDRL_IO, r);
        `CHK(r, 8'h5A)
        wr(nva_pkg::ADDRH_IO, 8'hFF);
        rd(8'h42, r, 1'b0);
        `CHK(r, 8'h0F)
    endtask
    task automatic t_prog();
        prog(9'h1A5, 8'h3C, nva_pkg::MODE_ATOMIC);
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h0A)
        waitDone();
        `CHK(irqPending, 1'b1)
        prog(9'h0A5, 8'h5E, nva_pkg::MODE_ATOMIC);
        waitDone();
        rdByte(9'h1A5, r);
        `CHK(r, 8'h3C)
        for (int i = 0; i < 3; i++) begin
            prog(9'h0A5, DV[i], MD[i]);
            waitDone();
            rdByte(9'h0A5, r);
            `CHK(r, EX[i])
        end
        irqEnable = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(irqPending, 1'b0)
        irqEnable = 1'b1;
    endtask
    task automatic t_arm();
        wr(nva_pkg::CTRL_IO, 8'h02);
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h00)
        bs(nva_pkg::ARM_B);
        repeat (6) @(negedge clk_sys);
        bs(nva_pkg::STROBE_B);
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h00)
        bs(nva_pkg::ARM_B);
        bs(nva_pkg::STROBE_B);
        selfProgramBusy = 1'b1;
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h04)
        selfProgramBusy = 1'b0;
    endtask
    task automatic t_refuse();
        prog(9'h005, 8'hA5, nva_pkg::MODE_ATOMIC);
        wr(nva_pkg::ADDRL_IO, 8'h06);
        wr(nva_pkg::CTRL_IO, 8'h21);
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h02)
        waitDone();
        rd(nva_pkg::ADDRL_IO, r);
        `CHK(r, 8'h05)
        rd(nva_pkg::DATA_IO, r);
        `CHK(r, 8'hA5)
        rdByte(9'h005, r);
        `CHK(r, 8'hA5)
    endtask
    task automatic t_reset();
        wr(nva_pkg::CTRL_IO, 8'h10);
        doReset();
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h00)
        prog(9'h000, 8'h00, nva_pkg::MODE_ERASE);
        doReset();
        rd(nva_pkg::CTRL_IO, r);
        `CHK(r, 8'h12)
        waitDone();
        rdByte(9'h000, r);
        `CHK(r, 8'hFF)
    endtask

    // ------------------------------------------------------------
    // verdict, clocks, watchdog, main sequence
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // oscillator, not a multiple of clk_sys
    initial begin
        rcClk = 1'b0;
        forever #53 rcClk = ~rcClk;
    end
    initial begin
        #300000;
        fails++;
        finish_test();
    end
    initial begin
        {resetn, porResetn, cmdValid, cmdWrite, cmdIoSpace, cmdBitOp} = 6'h00;
        {cmdAddr, cmdData, cmdBit, irqEnable, selfProgramBusy} = 21'h0;
        fails = 0;
        tests_run = 0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        {resetn, porResetn, irqEnable} = 3'h7;
        repeat (3) @(negedge clk_sys);
        t_map();
        t_prog();
        t_arm();
        t_refuse();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
